/* File: gtc_cfg.svh */
// Offsets, field positions and reset values of the timer/counter.
// Included by the package user files; holds definitions only.
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH

`define GTC_NMATCH 4

`define GTC_OFS_CTRL 8'h00
`define GTC_OFS_TC 8'h04
`define GTC_OFS_PR 8'h08
`define GTC_OFS_PC 8'h0c
`define GTC_OFS_MCR 8'h10
`define GTC_OFS_EMR 8'h14
`define GTC_OFS_CCR 8'h18
`define GTC_OFS_PWM 8'h1c
`define GTC_OFS_DMA 8'h20
`define GTC_OFS_IR 8'h24
`define GTC_OFS_IMSK 8'h28
`define GTC_OFS_MR_HI 4'h3
`define GTC_OFS_CR_HI 4'h4

`define GTC_CTRL_W 8
`define GTC_CTRL_EN 0
`define GTC_CTRL_CRST 1
`define GTC_CTRL_CNT 2
`define GTC_CTRL_XRISE 3
`define GTC_CTRL_XFALL 4
`define GTC_CTRL_CLR 5
`define GTC_CTRL_CSEL 6

`define GTC_MC_W 3
`define GTC_MC_INT 0
`define GTC_MC_RST 1
`define GTC_MC_STOP 2

`define GTC_CC_W 3
`define GTC_CC_RISE 0
`define GTC_CC_FALL 1
`define GTC_CC_INT 2

`define GTC_CTRL_RST 8'h00
`define GTC_PR_RST 32'h0000_0000

`endif

/* File: gtc_pkg.sv */
// Types shared by the timer/counter files.
// Assumes nothing beyond a SystemVerilog compiler.
package gtc_pkg;

    typedef enum logic [2:0] {
        GTC_BUS_IDLE = 3'b001,
        GTC_BUS_WR = 3'b010,
        GTC_BUS_RD = 3'b100
    } gtc_bus_t;

    typedef enum logic [1:0] {
        GTC_ACT_NONE = 2'h0,
        GTC_ACT_LOW = 2'h1,
        GTC_ACT_HIGH = 2'h2,
        GTC_ACT_TOG = 2'h3
    } gtc_act_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } gtc_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } gtc_ahb_rsp_t;

endpackage

/* File: gtc_shadow_mem.sv */
// Shadow words for the match values, one write port, all words out.
// Assumes writes come from the bus data phase on the same clock.
module gtc_shadow_mem #(
    parameter int N = 4,
    parameter int W = 32
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Write port
    input wire logic we_i,
    input wire logic [$clog2(N)-1:0] idx_i,
    input wire logic [W-1:0] wdata_i,
    // Registered words
    output logic [N-1:0][W-1:0] q_o
);
    import gtc_pkg::*;

    typedef struct packed {
        logic [N-1:0][W-1:0] word;
    } gtc_mem_st_t;

    gtc_mem_st_t mem_r;
    gtc_mem_st_t mem_nxt;

    always_comb begin
        mem_nxt = mem_r;
        if (we_i) begin
            mem_nxt.word[idx_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mem_r <= '0;
        end else if (ce_i) begin
            mem_r <= mem_nxt;
        end
    end

    assign q_o = mem_r.word;
endmodule

/* File: gtc_top.sv */
// 32-bit timer/counter with prescaler, four matches, captures and PWM.
// Assumes one AHB-Lite master on core_clk_i; pins are asynchronous.
// Function
// - Prescaler gates every counter increment
// - Count core clocks or external clock edges
// - Four matches raise interrupts, counting continues
// - Match may halt the counter
// - Match may return counter to zero
// - Match writes land in shadow first
// - Match output cleared, set, toggled or held
// - Capture edge copies counter, optional interrupt
// - Two matches may request DMA
// - Capture event clears counter and prescaler
// - Single-edge PWM, period set by match
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`include "gtc_cfg.svh"

module gtc_top #(
    parameter int NCAP = 4,
    parameter int NDMA = 2
) (
    // Clock and control
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register bus
    input wire gtc_pkg::gtc_ahb_req_t ahb_req_i,
    output gtc_pkg::gtc_ahb_rsp_t ahb_rsp_o,
    // Pins
    input wire logic ext_clk_i,
    input wire logic [NCAP-1:0] cap_i,
    output logic [`GTC_NMATCH-1:0] match_o,
    // System
    output logic irq_o,
    output logic [NDMA-1:0] dma_req_o
);
    import gtc_pkg::*;

    localparam int NM = `GTC_NMATCH;
    localparam int NIR = NM + NCAP;

    typedef struct packed {
        gtc_bus_t bus;
        logic [7:0] addr;
        logic [31:0] hrdata;
        logic [`GTC_CTRL_W-1:0] ctrl;
        logic [31:0] tc;
        logic [31:0] pc;
        logic [31:0] pr;
        logic [NM*`GTC_MC_W-1:0] mcr;
        logic [2*NM-1:0] emr;
        logic [NCAP*`GTC_CC_W-1:0] ccr;
        logic [NM-1:0] pwm;
        logic [NDMA-1:0] dmae;
        logic [NIR-1:0] ir;
        logic [NIR-1:0] imsk;
        logic [NM-1:0][31:0] mr;
        logic [NCAP-1:0][31:0] cr;
        logic [2:0] xs;
        logic [NCAP-1:0][2:0] cs;
        logic [NM-1:0] mout;
        logic [NDMA-1:0] dma;
        logic irq;
    } gtc_st_t;

    gtc_st_t st_r;
    gtc_st_t st_nxt;

    logic [NM-1:0][31:0] shadow;
    logic [NM-1:0] hit;
    logic [NM-1:0] intm;
    logic [NM-1:0] rstm;
    logic [NM-1:0] stopm;
    logic [NCAP-1:0] cap_ev;
    logic [NCAP-1:0] cap_int;
    logic [3:0] cap_ev4;
    logic [1:0] csel;
    logic run;
    logic xedge;
    logic inc;
    logic tick;
    logic clr_now;
    logic xfer;
    logic addr_ok;
    logic wr_mr;
    logic [7:0] ofs;
    logic [31:0] rdata;

    assign run = st_r.ctrl[`GTC_CTRL_EN] && !st_r.ctrl[`GTC_CTRL_CRST];
    assign xedge = (st_r.ctrl[`GTC_CTRL_XRISE] && st_r.xs[1] && !st_r.xs[2])
        || (st_r.ctrl[`GTC_CTRL_XFALL] && !st_r.xs[1] && st_r.xs[2]);
    // Counter mode: only synchronised edges count, so ext clock < core/2
    assign inc = st_r.ctrl[`GTC_CTRL_CNT] ? xedge : 1'b1;
    assign tick = run && inc && (st_r.pc == st_r.pr);
    assign csel = st_r.ctrl[`GTC_CTRL_CSEL+1:`GTC_CTRL_CSEL];
    assign cap_ev4 = 4'(cap_ev);
    assign clr_now = st_r.ctrl[`GTC_CTRL_CLR] && cap_ev4[csel];
    // Reload only at a period boundary or while stopped, never mid-cycle
    assign xfer = !run || (tick && |(hit & rstm));
    assign addr_ok = ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hready;
    assign wr_mr = (st_r.bus == GTC_BUS_WR) && (st_r.addr[7:4] == `GTC_OFS_MR_HI);
    assign ofs = ahb_req_i.haddr[7:0];

    for (genvar i = 0; i < NM; i++) begin : g_match
        assign hit[i] = tick && (st_r.tc == st_r.mr[i]);
        assign intm[i] = st_r.mcr[i*`GTC_MC_W+`GTC_MC_INT];
        assign rstm[i] = st_r.mcr[i*`GTC_MC_W+`GTC_MC_RST];
        assign stopm[i] = st_r.mcr[i*`GTC_MC_W+`GTC_MC_STOP];
    end

    for (genvar j = 0; j < NCAP; j++) begin : g_cap
        assign cap_ev[j] = (st_r.ccr[j*`GTC_CC_W+`GTC_CC_RISE]
            && st_r.cs[j][1] && !st_r.cs[j][2])
            || (st_r.ccr[j*`GTC_CC_W+`GTC_CC_FALL]
            && !st_r.cs[j][1] && st_r.cs[j][2]);
        assign cap_int[j] = st_r.ccr[j*`GTC_CC_W+`GTC_CC_INT];
    end

    gtc_shadow_mem #(
        .N(NM),
        .W(32)
    ) u_shadow (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .we_i(wr_mr),
        .idx_i(st_r.addr[3:2]),
        .wdata_i(ahb_req_i.hwdata),
        .q_o(shadow)
    );

    always_comb begin
        rdata = '0;
        if (ofs == `GTC_OFS_CTRL) begin
            rdata = 32'(st_r.ctrl);
        end else if (ofs == `GTC_OFS_TC) begin
            rdata = st_r.tc;
        end else if (ofs == `GTC_OFS_PR) begin
            rdata = st_r.pr;
        end else if (ofs == `GTC_OFS_PC) begin
            rdata = st_r.pc;
        end else if (ofs == `GTC_OFS_MCR) begin
            rdata = 32'(st_r.mcr);
        end else if (ofs == `GTC_OFS_EMR) begin
            rdata = 32'({st_r.emr, st_r.mout});
        end else if (ofs == `GTC_OFS_CCR) begin
            rdata = 32'(st_r.ccr);
        end else if (ofs == `GTC_OFS_PWM) begin
            rdata = 32'(st_r.pwm);
        end else if (ofs == `GTC_OFS_DMA) begin
            rdata = 32'(st_r.dmae);
        end else if (ofs == `GTC_OFS_IR) begin
            rdata = 32'(st_r.ir);
        end else if (ofs == `GTC_OFS_IMSK) begin
            rdata = 32'(st_r.imsk);
        end else if (ofs[7:4] == `GTC_OFS_MR_HI) begin
            rdata = shadow[ofs[3:2]];
        end else if (ofs[7:4] == `GTC_OFS_CR_HI && 32'(ofs[3:2]) < NCAP) begin
            rdata = st_r.cr[ofs[3:2]];
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.xs = {st_r.xs[1:0], ext_clk_i};
        for (int j = 0; j < NCAP; j++) begin
            st_nxt.cs[j] = {st_r.cs[j][1:0], cap_i[j]};
        end
        // Address phase; zero wait states, read data registered here
        st_nxt.bus = GTC_BUS_IDLE;
        if (addr_ok && ahb_req_i.hwrite) begin
            st_nxt.bus = GTC_BUS_WR;
            st_nxt.addr = ofs;
        end else if (addr_ok) begin
            st_nxt.bus = GTC_BUS_RD;
            st_nxt.addr = ofs;
            st_nxt.hrdata = rdata;
        end
        // Data phase of a write
        if (st_r.bus == GTC_BUS_WR) begin
            if (st_r.addr == `GTC_OFS_CTRL) begin
                st_nxt.ctrl = ahb_req_i.hwdata[`GTC_CTRL_W-1:0];
            end else if (st_r.addr == `GTC_OFS_PR) begin
                st_nxt.pr = ahb_req_i.hwdata;
            end else if (st_r.addr == `GTC_OFS_MCR) begin
                st_nxt.mcr = ahb_req_i.hwdata[NM*`GTC_MC_W-1:0];
            end else if (st_r.addr == `GTC_OFS_EMR) begin
                st_nxt.mout = ahb_req_i.hwdata[NM-1:0];
                st_nxt.emr = ahb_req_i.hwdata[3*NM-1:NM];
            end else if (st_r.addr == `GTC_OFS_CCR) begin
                st_nxt.ccr = ahb_req_i.hwdata[NCAP*`GTC_CC_W-1:0];
            end else if (st_r.addr == `GTC_OFS_PWM) begin
                st_nxt.pwm = ahb_req_i.hwdata[NM-1:0];
            end else if (st_r.addr == `GTC_OFS_DMA) begin
                st_nxt.dmae = ahb_req_i.hwdata[NDMA-1:0];
            end else if (st_r.addr == `GTC_OFS_IR) begin
                st_nxt.ir = st_r.ir & ~ahb_req_i.hwdata[NIR-1:0];
            end else if (st_r.addr == `GTC_OFS_IMSK) begin
                st_nxt.imsk = ahb_req_i.hwdata[NIR-1:0];
            end
        end
        // Counter and prescaler; hardware outranks a same-cycle write
        if (st_r.ctrl[`GTC_CTRL_CRST]) begin
            st_nxt.tc = '0;
            st_nxt.pc = '0;
        end else if (tick) begin
            st_nxt.pc = '0;
            if (|(hit & rstm)) begin
                st_nxt.tc = '0;
            end else if (!(|(hit & stopm))) begin
                st_nxt.tc = st_r.tc + 32'h1;
            end
            if (|(hit & stopm)) begin
                st_nxt.ctrl[`GTC_CTRL_EN] = 1'b0;
            end
        end else if (run && inc) begin
            st_nxt.pc = st_r.pc + 32'h1;
        end
        for (int i = 0; i < NM; i++) begin
            if (hit[i] && intm[i]) begin
                st_nxt.ir[i] = 1'b1;
            end
            if (hit[i] && !st_r.pwm[i]) begin
                case (gtc_act_t'(st_r.emr[2*i+:2]))
                    GTC_ACT_LOW: st_nxt.mout[i] = 1'b0;
                    GTC_ACT_HIGH: st_nxt.mout[i] = 1'b1;
                    GTC_ACT_TOG: st_nxt.mout[i] = !st_r.mout[i];
                    default: st_nxt.mout[i] = st_r.mout[i];
                endcase
            end
        end
        for (int d = 0; d < NDMA; d++) begin
            st_nxt.dma[d] = hit[d] && st_r.dmae[d];
        end
        for (int j = 0; j < NCAP; j++) begin
            if (cap_ev[j]) begin
                st_nxt.cr[j] = st_r.tc;
                st_nxt.ir[NM+j] = st_nxt.ir[NM+j] | cap_int[j];
            end
        end
        if (clr_now) begin
            st_nxt.tc = '0;
            st_nxt.pc = '0;
        end
        if (xfer) begin
            st_nxt.mr = shadow;
        end
        for (int i = 0; i < NM; i++) begin
            if (st_r.pwm[i]) begin
                st_nxt.mout[i] = st_nxt.tc >= st_r.mr[i];
            end
        end
        st_nxt.irq = |(st_nxt.ir & st_nxt.imsk);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.bus <= GTC_BUS_IDLE;
            st_r.ctrl <= `GTC_CTRL_RST;
            st_r.pr <= `GTC_PR_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign ahb_rsp_o = '{hrdata: st_r.hrdata, hreadyout: 1'b1, hresp: 1'b0};
    assign match_o = st_r.mout;
    assign irq_o = st_r.irq;
    assign dma_req_o = st_r.dma;

    default clocking gtc_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    presc_step_a: assert property (
        ce_i && run && inc && !tick && !clr_now |=> st_r.pc == $past(st_r.pc) + 32'h1)
        else $error("prescaler did not step");
    tick_inc_a: assert property (
        ce_i && tick && !(|(hit & (rstm | stopm))) && !clr_now
        |=> st_r.tc == $past(st_r.tc) + 32'h1 && st_r.pc == 32'h0)
        else $error("counter missed prescaled tick");
    presc_gate_a: assert property (
        ce_i && !tick && !clr_now && !st_r.ctrl[`GTC_CTRL_CRST] |=> $stable(st_r.tc))
        else $error("counter moved without tick");
    ext_hold_a: assert property (
        ce_i && st_r.ctrl[`GTC_CTRL_CNT] && !xedge && !clr_now
        && !st_r.ctrl[`GTC_CTRL_CRST] |=> $stable(st_r.pc) && $stable(st_r.tc))
        else $error("counter mode moved without edge");
    match_irq_a: assert property (
        ce_i && |(hit & intm)
        |=> (st_r.ir[NM-1:0] & $past(hit & intm)) == $past(hit & intm))
        else $error("match flag not set");
    match_stop_a: assert property (
        ce_i && |(hit & stopm) |=> !st_r.ctrl[`GTC_CTRL_EN] ##1 !tick)
        else $error("stop on match failed");
    match_rst_a: assert property (
        ce_i && |(hit & rstm) |=> st_r.tc == 32'h0 && st_r.pc == 32'h0)
        else $error("reset on match failed");
    shadow_hold_a: assert property (
        ce_i && !xfer |=> $stable(st_r.mr))
        else $error("active match changed mid-period");
    out_toggle_a: assert property (
        ce_i && hit[1] && !st_r.pwm[1] && st_r.emr[3:2] == GTC_ACT_TOG
        |=> match_o[1] != $past(match_o[1]))
        else $error("match output did not toggle");
    cap_copy_a: assert property (
        ce_i && cap_ev[0] |=> st_r.cr[0] == $past(st_r.tc))
        else $error("capture lost count");
    dma_pulse_a: assert property (
        ce_i && hit[0] && st_r.dmae[0] |=> dma_req_o[0])
        else $error("dma request missing");
    cap_clear_a: assert property (
        ce_i && clr_now |=> st_r.tc == 32'h0 && st_r.pc == 32'h0)
        else $error("capture clear failed");
    pwm_level_a: assert property (
        ce_i && st_r.pwm[1] && !xfer |=> match_o[1] == (st_r.tc >= st_r.mr[1]))
        else $error("pwm level wrong");
    irq_level_a: assert property (
        irq_o == |(st_r.ir & st_r.imsk))
        else $error("irq does not follow masked status");

    match_rst_c: cover property (ce_i && |(hit & rstm) ##1 st_r.tc == 32'h0);
    match_stop_c: cover property (ce_i && |(hit & stopm));
    capture_c: cover property (ce_i && cap_ev[0] && cap_int[0]);
    pwm_c: cover property (st_r.pwm[1] && match_o[1] ##1 !match_o[1]);
endmodule

/* File: gtc_pin_model.sv */
// Pin-side model: external count clock and capture inputs of the timer.
// Assumes the core clock of the bench; edges are spaced for the synchronisers.
module gtc_pin_model #(
    parameter int NCAP = 4
) (
    // Clock
    input wire logic clk_i,
    // Pins toward the timer
    output logic ext_clk_o,
    output logic [NCAP-1:0] cap_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ext_clk_o = 1'b0;
        cap_o = '0;
    end

    // Each level held 3 cycles, safely above the 2-cycle synchroniser need
    task automatic hold3();
        repeat (3) @(posedge clk_i);
    endtask

    task automatic pulse_ext(input int n);
        repeat (n) begin
            @(posedge clk_i);
            ext_clk_o <= 1'b1;
            hold3();
            ext_clk_o <= 1'b0;
            hold3();
        end
    endtask

    task automatic pulse_cap(input int j);
        @(posedge clk_i);
        cap_o[j] <= 1'b1;
        hold3();
        cap_o[j] <= 1'b0;
        hold3();
    endtask
endmodule

/* File: gtc_top_tb_top.sv */
// Self-checking bench of the timer/counter through its AHB-Lite registers.
// Assumes the pin model on ext and capture pins; ce_i stays high.
module gtc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gtc_pkg::*;

    logic clk;
    logic rst_n;
    gtc_ahb_req_t req;
    gtc_ahb_req_t req_w;
    gtc_ahb_rsp_t rsp;
    logic ext_clk;
    logic [3:0] cap;
    logic [3:0] match;
    logic irq;
    logic [1:0] dma;
    int err_count;
    int samples_checked;
    int dma_n;
    int tog_n;
    int d1_n;
    int n;
    logic m1_q;
    logic [31:0] v;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always_comb begin
        req_w = req;
        req_w.hready = rsp.hreadyout;
    end

    // Counts one-cycle DMA 0 pulses and match output 1 changes after reset
    always @(posedge clk) begin
        if (!rst_n) begin
            dma_n <= 0;
            tog_n <= 0;
        end else begin
            if (dma[0] === 1'b1) dma_n <= dma_n + 1;
            if (match[1] !== m1_q) tog_n <= tog_n + 1;
        end
        m1_q <= match[1];
    end

    gtc_top DUT (
        .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
        .ahb_req_i(req_w), .ahb_rsp_o(rsp),
        .ext_clk_i(ext_clk), .cap_i(cap), .match_o(match),
        .irq_o(irq), .dma_req_o(dma)
    );

    gtc_pin_model #(.NCAP(4)) PIN (.clk_i(clk), .ext_clk_o(ext_clk), .cap_o(cap));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for hready; only the watchdog ends a stuck wait
    task automatic wait_rdy();
        do begin
            @(posedge clk);
        end while (rsp.hreadyout !== 1'b1);
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        req.hsel <= 1'b1;
        req.htrans <= 2'h2;
        req.haddr <= {24'h0, a};
        req.hwrite <= w;
        req.hsize <= 3'h2;
        wait_rdy();
        req.htrans <= 2'h0;
        req.hsel <= 1'b0;
        req.hwdata <= d;
        wait_rdy();
        q = rsp.hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(q, e);
        chk({31'h0, rsp.hresp}, 32'h0);
    endtask

    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #200us;
        err_count++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        req = '0;
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h2c, 32'h0);
        chk({27'h0, irq, match}, 32'h0);
        // Stop on match 0 at 7, prescale 4, output set high, DMA on match 0
        wr(8'h28, 32'h1);
        wr(8'h30, 32'h7);
        wr(8'h10, 32'h5);
        wr(8'h14, 32'h20);
        wr(8'h20, 32'h1);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= 24 && n <= 40}, 32'h1);
        rd(8'h04, 32'h7);
        rd(8'h00, 32'h0);
        rd(8'h24, 32'h1);
        chk({31'h0, match[0]}, 32'h1);
        chk(dma_n, 32'h1);
        wr(8'h04, 32'h55);
        rd(8'h04, 32'h7);
        // Write one to clear removes the interrupt
        wr(8'h24, 32'h1);
        rd(8'h24, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Rising capture on pin 0 with its interrupt, counter frozen at 7
        wr(8'h18, 32'h5);
        wr(8'h28, 32'h10);
        PIN.pulse_cap(0);
        rd(8'h40, 32'h7);
        rd(8'h24, 32'h10);
        chk({31'h0, irq}, 32'h1);
        wr(8'h24, 32'h10);
        // Counter mode on external rising edges, no prescaling
        wr(8'h10, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h2);
        wr(8'h00, 32'hd);
        PIN.pulse_ext(5);
        repeat (6) @(posedge clk);
        wr(8'h00, 32'hc);
        rd(8'h04, 32'h5);
        // Reset on match 1 at 4 with toggling output 1, counting continues
        wr(8'h00, 32'h2);
        wr(8'h34, 32'h4);
        wr(8'h10, 32'h18);
        wr(8'h14, 32'hc0);
        wr(8'h00, 32'h1);
        repeat (50) @(posedge clk);
        wr(8'h00, 32'h0);
        xfer(8'h04, 1'b0, 32'h0, v);
        chk({31'h0, v <= 32'h4}, 32'h1);
        rd(8'h24, 32'h2);
        chk({31'h0, tog_n >= 5}, 32'h1);
        // Clear on capture 0: counter restarts from zero at the edge
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h21);
        repeat (30) @(posedge clk);
        PIN.pulse_cap(0);
        wr(8'h00, 32'h20);
        xfer(8'h04, 1'b0, 32'h0, v);
        chk({31'h0, v <= 32'h14}, 32'h1);
        // PWM on output 1: period 10 from match 3, high from count 4
        wr(8'h00, 32'h2);
        wr(8'h3c, 32'h9);
        wr(8'h10, 32'h400);
        wr(8'h1c, 32'h2);
        wr(8'h20, 32'h2);
        wr(8'h00, 32'h1);
        repeat (5) @(posedge clk);
        n = 0;
        d1_n = 0;
        repeat (100) begin
            @(posedge clk);
            if (match[1] === 1'b1) n++;
            if (dma[1] === 1'b1) d1_n++;
        end
        chk(n, 32'h3c);
        chk(d1_n, 32'ha);
        conclude();
    end
endmodule
